// *** logic/asb_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asb_map.svh"
module asb_seq #(
  parameter int unsigned GAP_UNIT_CYC = `ASB_GAP_UNIT_CYC,
  parameter int unsigned GAP_BASE_CYC = `ASB_GAP_BASE_CYC,
  parameter int unsigned PTR_W = `ASB_PTR_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_link_clk,
  input wire logic [7:0] i_serial_mode_register,
  input wire logic i_auto_reload_select,
  input wire logic i_inbound_capture_on,
  input wire logic i_gap_ctrl_enable,
  input wire logic [4:0] i_transfer_gap_setting,
  input wire logic i_ptr_load,
  input wire logic [PTR_W-1:0] i_ptr_value,
  input wire logic i_shift_wr,
  input wire logic [7:0] i_shift_wdata,
  input wire logic i_cpu_ram_en,
  input wire logic i_cpu_ram_we,
  input wire logic [PTR_W-1:0] i_cpu_ram_addr,
  input wire logic [7:0] i_cpu_ram_wdata,
  input wire logic i_irq_clear,
  input wire logic i_serial_data_input_pin,
  output logic [7:0] o_cpu_ram_rdata,
  output logic [PTR_W-1:0] o_buffer_index_pointer,
  output logic [7:0] o_auto_transfer_control,
  output logic o_transfer_active_flag,
  output logic o_serial_interrupt_flag,
  output logic o_serial_done_interrupt,
  output logic [15:0] o_buf_access_addr,
  output var asb_pkg::asb_mode_t o_run_mode,
  output logic o_serial_data_output_pin,
  output logic o_si_port_release,
  output logic o_handshake_pulse_port_release,
  output logic o_busy_port_release
);
  import asb_pkg::*;

  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

  // ==========================================
  // System domain state
  asb_state_t state_reg, state_next;
  asb_mode_t mode_reg, mode_next, mode_dec;
  logic [PTR_W-1:0] ptr_reg, ptr_next, start_ptr_reg, start_ptr_next;
  logic trf_reg, trf_next, susp_reg, susp_next;
  logic flag_reg, flag_next, done_reg, done_next;
  logic [7:0] tx_reg, tx_next;
  logic req_tgl_reg, req_tgl_next, ack_seen_reg, ack_seen_next;
  logic ack_s1_reg, ack_s2_reg;
  logic [15:0] gap_cnt_reg, gap_cnt_next, gap_load;
  logic [15:0] acc_reg, acc_next;
  logic si_rel_reg, si_rel_next;
  logic [31:0] gap_calc;
  logic seq_en, seq_we, spe, start_ok;
  logic mem_en, mem_we;
  logic [PTR_W-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;

  // ==========================================
  // Link domain state
  logic req_s1_reg, req_s2_reg, req_seen_reg, req_seen_next;
  logic act_s1_reg, act_s2_reg, si_s1_reg, si_s2_reg;
  logic lbusy_reg, lbusy_next, ack_tgl_reg, ack_tgl_next;
  logic so_reg, so_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, rx_reg, rx_next;

  assign spe = i_serial_mode_register[`ASB_MODE_SPE_BIT];

  always_comb begin
    case ({i_auto_reload_select, i_inbound_capture_on})
      2'b01: mode_dec = M_TXRX;
      2'b00: mode_dec = M_TX;
      2'b10: mode_dec = M_REPEAT;
      default: mode_dec = M_NONE;
    endcase
  end

  // The written value itself never reaches the shifter
  assign start_ok = i_shift_wr && spe && i_serial_mode_register[`ASB_MODE_ATE_BIT]
    && (mode_dec != M_NONE);

  assign gap_calc = (32'(i_transfer_gap_setting) + 32'h0000_0001) * GAP_UNIT_CYC
    + GAP_BASE_CYC;
  assign gap_load = i_gap_ctrl_enable ? (gap_calc[15:0] - 16'h0001)
    : (`ASB_GAP_MIN_CYC - 16'h0001);

  // ==========================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    ptr_next = ptr_reg;
    start_ptr_next = start_ptr_reg;
    trf_next = trf_reg;
    susp_next = susp_reg;
    done_next = 1'b0;
    tx_next = tx_reg;
    req_tgl_next = req_tgl_reg;
    ack_seen_next = ack_seen_reg;
    gap_cnt_next = gap_cnt_reg;
    seq_en = 1'b0;
    seq_we = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (i_ptr_load) begin
          ptr_next = i_ptr_value;
        end
        if (start_ok) begin
          trf_next = 1'b1;
          mode_next = mode_dec;
          susp_next = 1'b0;
          // A resume keeps the original repeat start point
          if (!susp_reg) begin
            start_ptr_next = i_ptr_load ? i_ptr_value : ptr_reg;
          end
          state_next = S_FETCH;
        end
      end
      S_FETCH: begin
        // Processor owns the buffer first, so the gap stretches
        if (!i_cpu_ram_en) begin
          seq_en = 1'b1;
          state_next = S_LOAD;
        end
      end
      S_LOAD: begin
        tx_next = mem_rdata;
        req_tgl_next = ~req_tgl_reg;
        state_next = S_XFER;
      end
      S_XFER: begin
        if (ack_s2_reg != ack_seen_reg) begin
          ack_seen_next = ack_s2_reg;
          state_next = (mode_reg == M_TXRX) ? S_STORE : S_STEP;
        end
      end
      S_STORE: begin
        if (!i_cpu_ram_en) begin
          seq_en = 1'b1;
          seq_we = 1'b1;
          state_next = S_STEP;
        end
      end
      S_STEP: begin
        gap_cnt_next = gap_load;
        if (ptr_reg == '0) begin
          if (mode_reg == M_REPEAT) begin
            ptr_next = start_ptr_reg;
            state_next = spe ? S_GAP : S_IDLE;
            susp_next = !spe;
            trf_next = spe;
          end else begin
            trf_next = 1'b0;
            done_next = 1'b1;
            state_next = S_IDLE;
          end
        end else begin
          ptr_next = ptr_reg - PTR_ONE;
          if (!spe) begin
            susp_next = 1'b1;
            trf_next = 1'b0;
            state_next = S_IDLE;
          end else begin
            state_next = S_GAP;
          end
        end
      end
      S_GAP: begin
        if (gap_cnt_reg == '0) begin
          state_next = S_FETCH;
        end else begin
          gap_cnt_next = gap_cnt_reg - 16'h0001;
        end
      end
      default: state_next = S_IDLE;
    endcase
    // A new completion beats a clear in the same cycle
    flag_next = (flag_reg && !i_irq_clear) || done_next;
    acc_next = seq_en ? (`ASB_WIN_BASE + 16'(ptr_reg)) : acc_reg;
    // for the released input pin
    si_rel_next = !(spe && (trf_reg || mode_dec == M_TXRX) && mode_reg == M_TXRX);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      mode_reg <= M_TX;
      ptr_reg <= '0;
      start_ptr_reg <= '0;
      trf_reg <= 1'b0;
      susp_reg <= 1'b0;
      flag_reg <= 1'b0;
      done_reg <= 1'b0;
      tx_reg <= 8'h00;
      req_tgl_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      gap_cnt_reg <= 16'h0000;
      acc_reg <= `ASB_WIN_BASE;
      si_rel_reg <= 1'b1;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      ptr_reg <= ptr_next;
      start_ptr_reg <= start_ptr_next;
      trf_reg <= trf_next;
      susp_reg <= susp_next;
      flag_reg <= flag_next;
      done_reg <= done_next;
      tx_reg <= tx_next;
      req_tgl_reg <= req_tgl_next;
      ack_seen_reg <= ack_seen_next;
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      gap_cnt_reg <= gap_cnt_next;
      acc_reg <= acc_next;
      si_rel_reg <= si_rel_next;
    end
  end

  // ==========================================
  // Buffer sharing, processor first
  assign mem_en = i_cpu_ram_en || seq_en;
  assign mem_we = i_cpu_ram_en ? i_cpu_ram_we : seq_we;
  assign mem_addr = i_cpu_ram_en ? i_cpu_ram_addr : ptr_reg;
  // Shift data is static here: the link idles until the next request
  assign mem_wdata = i_cpu_ram_en ? i_cpu_ram_wdata : rx_reg;

  asb_buf_ram #(
    .DEPTH(`ASB_WIN_BYTES),
    .AW(PTR_W),
    .DW(8)
  ) u_ram (
    .i_clk(i_sys_clk),
    .i_clk_en(i_clk_en),
    .i_en(mem_en),
    .i_we(mem_we),
    .i_addr(mem_addr),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  // ==========================================
  // Link shifter, on the serial clock
  always_comb begin
    req_seen_next = req_seen_reg;
    lbusy_next = lbusy_reg;
    ack_tgl_next = ack_tgl_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    rx_next = rx_reg;
    so_next = act_s2_reg ? so_reg : 1'b0;
    if (lbusy_reg) begin
      cnt_next = cnt_reg + 4'h1;
      if (cnt_reg < `ASB_TX_LAST) begin
        sh_next = {sh_reg[6:0], 1'b0};
        so_next = sh_reg[6];
      end else begin
        so_next = act_s2_reg ? so_reg : 1'b0;
      end
      // Input lags two clocks through its synchroniser
      if (cnt_reg >= `ASB_RX_FIRST) begin
        rx_next = {rx_reg[6:0], si_s2_reg};
      end
      if (cnt_reg == `ASB_BIT_LAST) begin
        lbusy_next = 1'b0;
        ack_tgl_next = ~ack_tgl_reg;
      end
    end else if (req_s2_reg != req_seen_reg) begin
      req_seen_next = req_s2_reg;
      lbusy_next = 1'b1;
      cnt_next = 4'h0;
      sh_next = tx_reg;
      so_next = tx_reg[7];
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      act_s1_reg <= 1'b0;
      act_s2_reg <= 1'b0;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
      req_seen_reg <= 1'b0;
      lbusy_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      so_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      act_s1_reg <= trf_reg;
      act_s2_reg <= act_s1_reg;
      si_s1_reg <= i_serial_data_input_pin;
      si_s2_reg <= si_s1_reg;
      req_seen_reg <= req_seen_next;
      lbusy_reg <= lbusy_next;
      ack_tgl_reg <= ack_tgl_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      rx_reg <= rx_next;
      so_reg <= so_next;
    end
  end

  // ==========================================
  // Outputs
  assign o_cpu_ram_rdata = mem_rdata;
  assign o_buffer_index_pointer = ptr_reg;
  always_comb begin
    o_auto_transfer_control = `ASB_CTRL_RST;
    o_auto_transfer_control[`ASB_CTRL_TRF_BIT] = trf_reg;
  end
  assign o_transfer_active_flag = trf_reg;
  assign o_serial_interrupt_flag = flag_reg;
  assign o_serial_done_interrupt = done_reg;
  assign o_buf_access_addr = acc_reg;
  assign o_run_mode = mode_reg;
  assign o_serial_data_output_pin = so_reg;
  assign o_si_port_release = si_rel_reg;
  // No busy or strobe handshake here, so both pins stay ports
  assign o_handshake_pulse_port_release = 1'b1;
  assign o_busy_port_release = 1'b1;

  // ==========================================
  // Checks
  sequence s_fetch_load;
    (state_reg == S_FETCH && seq_en && i_clk_en) ##1 (state_reg == S_LOAD && i_clk_en);
  endsequence

  a_start_run: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == S_IDLE && start_ok && i_clk_en) |=> (trf_reg && state_reg == S_FETCH))
    else $error("start trigger did not begin a run");
  a_start_refused: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == S_IDLE && i_shift_wr && !spe && i_clk_en) |=> !trf_reg)
    else $error("trigger with port disabled started a run");
  a_load_request: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_fetch_load |=> (tx_reg == $past(mem_rdata) && req_tgl_reg != $past(req_tgl_reg)))
    else $error("fetched byte not handed to shifter");
  a_store_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (seq_en && seq_we) |-> (mode_reg == M_TXRX && state_reg == S_STORE))
    else $error("buffer write outside transmit/receive store");
  a_ptr_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == S_STEP && ptr_reg != '0 && i_clk_en) |=> ptr_reg == $past(ptr_reg) - PTR_ONE)
    else $error("pointer not decremented by one");
  a_end_basic: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == S_STEP && ptr_reg == '0 && mode_reg != M_REPEAT && i_clk_en)
    |=> (!trf_reg && done_reg && flag_reg && state_reg == S_IDLE))
    else $error("basic run end did not clear active and raise flag");
  a_repeat_reload: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == S_STEP && ptr_reg == '0 && mode_reg == M_REPEAT && i_clk_en)
    |=> (!done_reg && ptr_reg == start_ptr_reg))
    else $error("repeat wrap raised flag or missed reload");
  a_gap_entry: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == S_STEP && ptr_reg != '0 && spe && i_clk_en)
    |=> (state_reg == S_GAP && gap_cnt_reg == $past(gap_load)))
    else $error("gap not loaded with programmed length");
  a_suspend_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state_reg == S_STEP && ptr_reg != '0 && !spe && i_clk_en) |=> (susp_reg && !trf_reg))
    else $error("disable did not suspend after the byte");
  a_access_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (seq_en && i_clk_en) |=> o_buf_access_addr == `ASB_WIN_BASE + 16'($past(ptr_reg)))
    else $error("access address not base plus pointer");
  a_byte_frame: assert property (@(posedge i_link_clk) disable iff (i_rst)
    $rose(lbusy_reg) |-> lbusy_reg [*8] ##1 lbusy_reg ##1 lbusy_reg ##1 !lbusy_reg)
    else $error("link byte frame not ten clocks");
  a_so_low_idle: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (!act_s2_reg && !lbusy_reg) |=> !o_serial_data_output_pin)
    else $error("data output not low with run inactive");
endmodule // asb_seq
`default_nettype wire

// *** logic/asb_map.svh ***
`ifndef ASB_MAP_SVH
`define ASB_MAP_SVH
// Behaviour
// - Reload clear, capture set: transmit/receive
// - Both clear: transmit-only, nothing stored
// - Reload set, capture clear: repeat transmit
// - Shift write starts run, value discarded
// - Pointed entry loaded, shifted over eight clocks
// - Received byte stored before pointer decrement
// - Decrement until pointer zero byte sent
// - Termination clears transfer active flag
// - Basic modes raise done flag after last
// - Repeat: no flag, reload pointer, resend
// - Gap between bytes for shared buffer
// - Active flag clear drives data output low
// - Unused handshake pins released as ports
// - Gap at least (n+1)*128+56 clocks
// - Port disable suspends after current byte

// ==========================================
// Buffer window
`define ASB_WIN_BASE 16'hfac0
`define ASB_WIN_TOP 16'hfaff
`define ASB_WIN_BYTES 64
`define ASB_PTR_W 6
// ==========================================
// Field positions and reset values
`define ASB_MODE_SPE_BIT 7
`define ASB_MODE_ATE_BIT 5
`define ASB_CTRL_TRF_BIT 3
`define ASB_CTRL_RST 8'h00
// ==========================================
// Timing counts, in system clocks or link clocks
`define ASB_GAP_UNIT_CYC 128
`define ASB_GAP_BASE_CYC 56
`define ASB_GAP_MIN_CYC 16'h0002
`define ASB_TX_LAST 4'h7
`define ASB_RX_FIRST 4'h2
`define ASB_BIT_LAST 4'h9
`endif

// *** logic/asb_pkg.sv ***
`default_nettype none
package asb_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH = 3'b001,
    S_LOAD = 3'b010,
    S_XFER = 3'b011,
    S_STORE = 3'b100,
    S_STEP = 3'b101,
    S_GAP = 3'b110
  } asb_state_t;
  typedef enum logic [1:0] {
    M_TXRX = 2'b00,
    M_TX = 2'b01,
    M_REPEAT = 2'b10,
    M_NONE = 2'b11
  } asb_mode_t;
endpackage
`default_nettype wire

// *** logic/asb_buf_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
module asb_buf_ram #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 8
) (
  input wire logic i_clk,
  input wire logic i_clk_en,
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;

  // ==========================================
  // Single port, read data registered
  always_comb begin
    rdata_next = rdata_reg;
    if (i_en && !i_we) begin
      rdata_next = mem[i_addr];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_clk_en) begin
      rdata_reg <= rdata_next;
      if (i_en && i_we) begin
        mem[i_addr] <= i_wdata;
      end
    end
  end

  assign o_rdata = rdata_reg;
endmodule // asb_buf_ram
`default_nettype wire

// *** verification/asb_link_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far-side serial device on the link
module asb_link_slave (
  input wire logic i_link_clk,
  input wire logic i_rst,
  input wire logic i_active,
  input wire logic i_rx_level,
  input wire logic i_sdo,
  input wire logic i_count_clr,
  output logic o_sdi,
  output logic [15:0] o_ones
);
  // Constant level while a run is active, so the captured byte does not hang on
  // bit alignment; outside a run the line toggles so a stale value never passes
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sdi <= 1'b0;
    end else if (i_active) begin
      o_sdi <= i_rx_level;
    end else begin
      o_sdi <= ~o_sdi;
    end
  end
  // Output changes on the rising edge, so each bit but the held last bit of a byte is seen at exactly one falling edge
  always_ff @(negedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ones <= 16'h0000;
    end else if (i_count_clr) begin
      o_ones <= 16'h0000;
    end else if (i_sdo) begin
      o_ones <= o_ones + 16'h0001;
    end
  end
endmodule // asb_link_slave
`default_nettype wire

// *** verification/asb_seq_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module asb_seq_bench;
  import asb_pkg::*;
  // ==========================================
  // Signals
  logic clk, lclk, rst, shift_wr, ptr_load, ram_en, ram_we, irq_clr, gap_en, auto_reload_select, cap;
  logic rx_level, cnt_clr, sdi, active, irq, done, sdo, si_rel, hs_rel, busy_rel;
  logic [7:0] mode_reg, ram_wdata, rdata, ctrl;
  logic [4:0] gap_n;
  logic [5:0] ptr_val, ram_addr, ptr;
  logic [15:0] acc_addr, ones;
  asb_mode_t run_mode;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_done = 0;
  int cyc;
  // ==========================================
  // Clocks; short gap units keep the run brief
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #2;
    forever begin
      lclk = ~lclk;
      #24;
    end
  end
  // Counted mid-cycle, away from the edge that launches the pulse
  always @(negedge clk) begin
    if (done === 1'b1) n_done++;
  end
  asb_seq #(.GAP_UNIT_CYC(4), .GAP_BASE_CYC(2)) DUT (
    .i_sys_clk(clk), .i_rst(rst), .i_clk_en(1'b1), .i_link_clk(lclk),
    .i_serial_mode_register(mode_reg), .i_auto_reload_select(auto_reload_select),
    .i_inbound_capture_on(cap), .i_gap_ctrl_enable(gap_en), .i_transfer_gap_setting(gap_n),
    .i_ptr_load(ptr_load), .i_ptr_value(ptr_val), .i_shift_wr(shift_wr),
    .i_shift_wdata(8'h5a), .i_cpu_ram_en(ram_en), .i_cpu_ram_we(ram_we),
    .i_cpu_ram_addr(ram_addr), .i_cpu_ram_wdata(ram_wdata), .i_irq_clear(irq_clr),
    .i_serial_data_input_pin(sdi), .o_cpu_ram_rdata(rdata), .o_buffer_index_pointer(ptr),
    .o_auto_transfer_control(ctrl), .o_transfer_active_flag(active),
    .o_serial_interrupt_flag(irq), .o_serial_done_interrupt(done),
    .o_buf_access_addr(acc_addr), .o_run_mode(run_mode), .o_serial_data_output_pin(sdo),
    .o_si_port_release(si_rel), .o_handshake_pulse_port_release(hs_rel),
    .o_busy_port_release(busy_rel)
  );
  asb_link_slave SLAVE (
    .i_link_clk(lclk), .i_rst(rst), .i_active(active), .i_rx_level(rx_level),
    .i_sdo(sdo), .i_count_clr(cnt_clr), .o_sdi(sdi), .o_ones(ones)
  );
  // ==========================================
  // Tasks, all entered just after a falling edge
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ram_wr(input logic [5:0] a, input logic [7:0] d);
    ram_en = 1'b1; ram_we = 1'b1; ram_addr = a; ram_wdata = d;
    @(negedge clk);
    ram_en = 1'b0; ram_we = 1'b0;
    // Idle cycle so a following access never re-raises the strobe in this step
    @(negedge clk);
  endtask
  task automatic ram_rd(input logic [5:0] a, input logic [7:0] exp);
    ram_en = 1'b1; ram_addr = a;
    @(negedge clk);
    ram_en = 1'b0;
    @(negedge clk);
    check("buffer byte", {8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic run_start(input logic [5:0] p);
    ptr_load = 1'b1; ptr_val = p;
    @(negedge clk);
    ptr_load = 1'b0; shift_wr = 1'b1;
    @(negedge clk);
    shift_wr = 1'b0;
    @(negedge clk);
  endtask
  // Kind 0: run idle, 1: pointer equals val, 2: access address at window base
  task automatic wait_for(input int kind, input logic [5:0] val, output int n);
    bit hit;
    hit = 0;
    for (n = 0; n < 4000 && !hit; n++) begin
      @(negedge clk);
      hit = (kind == 0) ? (active === 1'b0) : (kind == 1) ? (ptr === val)
          : (acc_addr === 16'hfac0);
    end
    if (!hit) begin
      n_mismatch++;
      $display("[FAIL] wait expected event seen timeout");
      conclude();
    end
  endtask
  task automatic clear_irq();
    irq_clr = 1'b1;
    @(negedge clk);
    irq_clr = 1'b0;
    check("irq after clear", {15'h0, irq}, 16'h0000);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1; shift_wr = 1'b0; ptr_load = 1'b0; ram_en = 1'b0; ram_we = 1'b0;
    irq_clr = 1'b0; gap_en = 1'b0; auto_reload_select = 1'b0; cap = 1'b1; rx_level = 1'b1;
    cnt_clr = 1'b1; mode_reg = 8'ha0; ram_wdata = 8'h00; gap_n = 5'h00;
    ptr_val = 6'h00; ram_addr = 6'h00;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check("active", {15'h0, active}, 16'h0000);
    check("pointer", {10'h0, ptr}, 16'h0000);
    check("access", acc_addr, 16'hfac0);
    check("data out", {15'h0, sdo}, 16'h0000);
    check("releases", {13'h0, si_rel, hs_rel, busy_rel}, 16'h0007);
    check("mode", {14'h0, run_mode}, {14'h0, M_TX});
    // Three bytes out and in; first byte from the highest offset
    ram_wr(6'h00, 8'h96);
    ram_wr(6'h01, 8'ha4);
    ram_wr(6'h02, 8'h3c);
    ram_wr(6'h03, 8'h77);
    cnt_clr = 1'b0;
    run_start(6'h02);
    check("active", {15'h0, active}, 16'h0001);
    check("control", {8'h0, ctrl}, 16'h0008);
    check("mode", {14'h0, run_mode}, {14'h0, M_TXRX});
    check("si release", {15'h0, si_rel}, 16'h0000);
    wait_for(0, 6'h00, cyc);
    check("control", {8'h0, ctrl}, 16'h0000);
    check("irq", {15'h0, irq}, 16'h0001);
    check("pointer", {10'h0, ptr}, 16'h0000);
    check("access", acc_addr, 16'hfac0);
    repeat (30) @(negedge clk);
    check("done pulses", n_done[15:0], 16'h0001);
    check("ones sent", ones, 16'd11);
    check("data out", {15'h0, sdo}, 16'h0000);
    ram_rd(6'h00, 8'hff);
    ram_rd(6'h01, 8'hff);
    ram_rd(6'h02, 8'hff);
    ram_rd(6'h03, 8'h77);
    clear_irq();
    // Transmit only with a long gap; received level differs from buffer content
    gap_en = 1'b1; gap_n = 5'h03; cap = 1'b0; rx_level = 1'b0;
    run_start(6'h01);
    check("mode", {14'h0, run_mode}, {14'h0, M_TX});
    check("si release", {15'h0, si_rel}, 16'h0001);
    wait_for(1, 6'h00, cyc);
    wait_for(2, 6'h00, cyc);
    check("gap ok", {15'h0, cyc >= 18}, 16'h0001);
    wait_for(0, 6'h00, cyc);
    check("irq", {15'h0, irq}, 16'h0001);
    ram_rd(6'h00, 8'hff);
    ram_rd(6'h01, 8'hff);
    check("done pulses", n_done[15:0], 16'h0002);
    clear_irq();
    // Starts that must be ignored
    gap_en = 1'b0; mode_reg = 8'h80;
    run_start(6'h01);
    check("active", {15'h0, active}, 16'h0000);
    mode_reg = 8'ha0; auto_reload_select = 1'b1; cap = 1'b1;
    run_start(6'h01);
    check("active", {15'h0, active}, 16'h0000);
    // Repeat: pointer reloads with no flag, then suspend by port disable
    cap = 1'b0;
    run_start(6'h01);
    check("mode", {14'h0, run_mode}, {14'h0, M_REPEAT});
    wait_for(1, 6'h00, cyc);
    wait_for(1, 6'h01, cyc);
    check("active", {15'h0, active}, 16'h0001);
    check("irq", {15'h0, irq}, 16'h0000);
    mode_reg = 8'h20;
    check("active", {15'h0, active}, 16'h0001);
    wait_for(0, 6'h00, cyc);
    check("done pulses", n_done[15:0], 16'h0002);
    check("irq", {15'h0, irq}, 16'h0000);
    repeat (30) @(negedge clk);
    check("data out", {15'h0, sdo}, 16'h0000);
    // Trigger with the port disabled must be ignored
    run_start(6'h01);
    check("active", {15'h0, active}, 16'h0000);
    conclude();
  end
endmodule // asb_seq_bench
`default_nettype wire
